// ---- core/adar_regs.svh ----
`ifndef ADAR_REGS_SVH
`define ADAR_REGS_SVH
// Register offsets on the serial register port
`define ADAR_ADDR_DELAY_ADJUST 12'h2B5
`define ADAR_ADDR_RAMP_CTRL 12'h2B8
// Field positions of the delay adjust register
`define ADAR_INV_BIT 16
`define ADAR_COARSE_HI 15
`define ADAR_COARSE_LO 8
`define ADAR_FINE_HI 7
`define ADAR_FINE_LO 0
// Field positions of the ramp control register
`define ADAR_RAMP_EN_BIT 0
`define ADAR_RAMP_RATE_BIT 1
// Reset values
`define ADAR_DELAY_RESET 24'h000000
`define ADAR_RAMP_RESET 8'h00
// Ramp timing in sampling clock cycles
`define ADAR_STEP_CYCLES 9'h180
`define ADAR_STEP_LAST 9'h17F
`define ADAR_CNT_ZERO 9'h000
`define ADAR_CNT_ONE 9'h001
`define ADAR_FAST_STEP 8'h04
`define ADAR_SLOW_STEP 8'h01
// Abrupt update limit in cycles; applied on the next edge here
`define ADAR_ABRUPT_LIMIT 11'h600
`endif

// ---- core/adar_pkg.sv ----
package adar_pkg;
    // Ramp engine states
    typedef enum logic [0:0] {
        ADAR_IDLE,
        ADAR_RAMP
    } adar_state_e;
    typedef logic [7:0] adar_code_t;
endpackage

// ---- core/adar_top.sv ----
// What this block does
// R1: Invert bit 16 inverts the sampling clock
// R2: Coarse code bits 15:8 set coarse delay
// R3: Fine code bits 7:0 set fine delay
// R4: Autocal enable overrides all manual delay settings
// R5: Fine code changes apply anytime, glitch free
// R6: Software changes invert only with enables clear
// R7: Software limits coarse moves to four codes
// R8: Software should step coarse one code
// R9: Ramp rate applies only when ramping enabled
// R10: Ramp one or four codes per 384
// R11: Ramp off: coarse applied abruptly after write
// R12: Ramp on: step applied code until target
// R13: Both registers reset to all zeros
// R14: Fast step clamps to land on target
// R15: Rewrite mid-ramp continues from applied code
`timescale 1ns/100ps
`default_nettype none
`include "adar_regs.svh"
module adar_top
    import adar_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic reg_wr, // Register write strobe
    input wire logic [11:0] reg_addr, // Register address
    input wire logic [23:0] reg_wdata, // Write data
    output logic [23:0] reg_rdata, // Read data
    input wire logic sysref_autocal_enable, // Calibration owns the delay
    input wire logic [16:0] autocal_delay, // Delay from calibration
    output logic sample_clock_invert, // Applied inversion
    output logic [7:0] coarse_applied, // Applied coarse code
    output logic [7:0] fine_applied, // Applied fine code
    output logic ramp_busy // Ramp in progress
);

    // Programmed registers
    logic [23:0] delay_q; // Delay adjust register
    logic [7:0] ramp_ctrl_q; // Ramp control register
    logic rate_q; // Ramp rate latched at the last delay write made with ramping on

    // Ramp engine state
    adar_state_e state_q; // Current ramp state
    adar_state_e state_d; // Next ramp state
    adar_code_t run_q; // Coarse code as moved by the ramp engine
    adar_code_t run_d; // Next ramp coarse code
    logic [8:0] cnt_q; // Cycles spent in the current ramp step
    logic [8:0] cnt_d; // Next step cycle count

    // Applied delay, held in flip-flops
    logic inv_q; // Applied inversion
    adar_code_t coarse_q; // Applied coarse code
    adar_code_t fine_q; // Applied fine code
    logic [23:0] rdata_q; // Registered read data

    // Decoded strobes and fields
    logic wr_delay; // Write to the delay adjust register
    logic wr_ramp; // Write to the ramp control register
    logic ramp_en; // Ramp feature enabled
    adar_code_t target; // Coarse code written by software
    adar_code_t step_size; // Codes moved per ramp step
    adar_code_t gap_up; // Distance when ramping upward
    adar_code_t gap_down; // Distance when ramping downward
    logic going_up; // Target lies above the ramp code
    logic step_due; // Step interval has elapsed
    adar_code_t run_up; // Clamped upward step
    adar_code_t run_dn; // Clamped downward step
    adar_code_t run_step; // Code after one ramp step
    adar_code_t manual_coarse; // Coarse code in manual control
    logic sel_inv; // Inversion to apply
    adar_code_t sel_coarse; // Coarse code to apply
    adar_code_t sel_fine; // Fine code to apply
    logic [23:0] read_mux; // Read data before the register

    // Address decode on the serial register port
    assign wr_delay = reg_wr && (reg_addr == `ADAR_ADDR_DELAY_ADJUST);
    assign wr_ramp = reg_wr && (reg_addr == `ADAR_ADDR_RAMP_CTRL);

    // Field extraction
    assign ramp_en = ramp_ctrl_q[`ADAR_RAMP_EN_BIT];
    assign target = delay_q[`ADAR_COARSE_HI:`ADAR_COARSE_LO]; // R2

    // Step size follows the rate latched at the write
    assign step_size = rate_q ? `ADAR_FAST_STEP : `ADAR_SLOW_STEP; // R9 R10

    // Distance to the target in each direction
    assign gap_up = target - run_q;
    assign gap_down = run_q - target;
    assign going_up = (target > run_q);

    // One step per fixed interval of sampling clock cycles
    assign step_due = (cnt_q == `ADAR_STEP_LAST); // R10

    // Last step is clamped so the code never passes the target
    assign run_up = (gap_up > step_size) ? (run_q + step_size) : target; // R14
    assign run_dn = (gap_down > step_size) ? (run_q - step_size) : target; // R14
    assign run_step = going_up ? run_up : run_dn; // R12

    // Ramp off: written code applies directly; ramp on: engine code
    assign manual_coarse = ramp_en ? run_q : target; // R11 R12

    // Calibration overrides every manual setting
    assign sel_inv = sysref_autocal_enable ? autocal_delay[`ADAR_INV_BIT]
        : delay_q[`ADAR_INV_BIT]; // R1 R4
    assign sel_coarse = sysref_autocal_enable
        ? autocal_delay[`ADAR_COARSE_HI:`ADAR_COARSE_LO] : manual_coarse; // R2 R4
    assign sel_fine = sysref_autocal_enable ? autocal_delay[`ADAR_FINE_HI:`ADAR_FINE_LO]
        : delay_q[`ADAR_FINE_HI:`ADAR_FINE_LO]; // R3 R4 R5

    // Read data selection
    assign read_mux = (reg_addr == `ADAR_ADDR_DELAY_ADJUST) ? delay_q
        : (reg_addr == `ADAR_ADDR_RAMP_CTRL) ? {16'h0000, ramp_ctrl_q}
        : 24'h000000;

    // Outputs
    assign sample_clock_invert = inv_q;
    assign coarse_applied = coarse_q;
    assign fine_applied = fine_q;
    assign ramp_busy = (state_q == ADAR_RAMP);

    // Register writes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // Both registers clear on reset
            delay_q <= `ADAR_DELAY_RESET; // R13
            ramp_ctrl_q <= `ADAR_RAMP_RESET; // R13
        end else begin
            // Each register takes its own write
            if (wr_delay) begin
                delay_q <= reg_wdata;
            end
            if (wr_ramp) begin
                ramp_ctrl_q <= reg_wdata[7:0];
            end
        end
    end

    // Rate only counts when a coarse write happens with ramping on
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // Slow rate after reset
            rate_q <= 1'b0; // R13
        end else if (wr_delay && ramp_en) begin
            // Capture the rate for this ramp
            rate_q <= ramp_ctrl_q[`ADAR_RAMP_RATE_BIT]; // R9
        end
    end

    // Ramp engine next state
    always_comb begin
        state_d = state_q;
        run_d = run_q;
        cnt_d = cnt_q;
        case (state_q)
            ADAR_IDLE: begin
                // Step counter rests at zero
                cnt_d = `ADAR_CNT_ZERO;
                if (!ramp_en) begin
                    // Track the target so a later ramp starts from it
                    run_d = target; // R11
                end else if (run_q != target) begin
                    // New target while ramping is on
                    state_d = ADAR_RAMP; // R12
                end
            end
            ADAR_RAMP: begin
                if (!ramp_en) begin
                    // Ramp switched off: jump to the target
                    run_d = target; // R11
                    cnt_d = `ADAR_CNT_ZERO;
                    state_d = ADAR_IDLE;
                end else if (run_q == target) begin
                    // Target reached
                    cnt_d = `ADAR_CNT_ZERO;
                    state_d = ADAR_IDLE; // R12
                end else if (step_due) begin
                    // A rewrite only moves the target; stepping goes on from here
                    run_d = run_step; // R12 R15
                    cnt_d = `ADAR_CNT_ZERO;
                end else begin
                    // Wait out the step interval
                    cnt_d = cnt_q + `ADAR_CNT_ONE; // R10
                end
            end
            default: begin
                // Unknown state returns to rest
                state_d = ADAR_IDLE;
                run_d = target;
                cnt_d = `ADAR_CNT_ZERO;
            end
        endcase
    end

    // Ramp engine registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // Idle with zero code
            state_q <= ADAR_IDLE;
            run_q <= 8'h00; // R13
            cnt_q <= `ADAR_CNT_ZERO;
        end else begin
            // Advance
            state_q <= state_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
        end
    end

    // Applied delay and read data registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // No inversion and zero delay
            inv_q <= 1'b0; // R13
            coarse_q <= 8'h00; // R13
            fine_q <= 8'h00; // R13
            rdata_q <= 24'h000000;
        end else begin
            // Take the selected settings every cycle
            inv_q <= sel_inv; // R1
            coarse_q <= sel_coarse; // R2
            fine_q <= sel_fine; // R3 R5
            rdata_q <= read_mux;
        end
    end

    assign reg_rdata = rdata_q;

    // Write of the delay register with calibration off for two cycles
    sequence fine_write_s;
        wr_delay && !sysref_autocal_enable ##1 !sysref_autocal_enable;
    endsequence

    // Same, with ramping off and not switched on meanwhile
    sequence manual_write_s;
        wr_delay && !ramp_en && !sysref_autocal_enable && !wr_ramp
            ##1 !sysref_autocal_enable && !wr_ramp;
    endsequence

    // A ramp step falls due before the target is reached
    sequence ramp_tick_s;
        (state_q == ADAR_RAMP) && ramp_en && step_due && (run_q != target);
    endsequence

    // Fine code follows a write at any time while calibration is off
    fine_follow_a: assert property (@(posedge mclk) disable iff (!nrst) // R3 R5
        fine_write_s |=> fine_q == $past(delay_q[`ADAR_FINE_HI:`ADAR_FINE_LO]))
        else $error("fine code not applied");

    // Inversion follows a write
    invert_follow_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
        fine_write_s |=> inv_q == $past(delay_q[`ADAR_INV_BIT]))
        else $error("inversion not applied");

    // Coarse code applies abruptly with ramping off
    coarse_abrupt_a: assert property (@(posedge mclk) disable iff (!nrst) // R2 R11
        manual_write_s |=> coarse_q == $past(delay_q[`ADAR_COARSE_HI:`ADAR_COARSE_LO]))
        else $error("coarse code not applied");

    // Calibration value replaces the manual settings
    autocal_override_a: assert property (@(posedge mclk) disable iff (!nrst) // R4
        sysref_autocal_enable |=> {inv_q, coarse_q, fine_q} == $past(autocal_delay))
        else $error("calibration delay not applied");

    // Ramp code holds between steps
    ramp_hold_a: assert property (@(posedge mclk) disable iff (!nrst) // R10
        (state_q == ADAR_RAMP) && ramp_en && !step_due |=> run_q == $past(run_q))
        else $error("ramp code moved between steps");

    // Each step is one or four codes, or lands on the target
    ramp_step_a: assert property (@(posedge mclk) disable iff (!nrst) // R10
        ramp_tick_s |=> (run_q == $past(target))
            || (run_q == $past(run_q) + (rate_q ? 8'h04 : 8'h01))
            || (run_q == $past(run_q) - (rate_q ? 8'h04 : 8'h01)))
        else $error("ramp step size wrong");

    // A step moves toward the target and never passes it
    ramp_clamp_a: assert property (@(posedge mclk) disable iff (!nrst) // R14
        ramp_tick_s |=> ($past(going_up) ? (run_q > $past(run_q) && run_q <= $past(target))
            : (run_q < $past(run_q) && run_q >= $past(target))))
        else $error("ramp step overshoots");

    // Without ramp enable the engine stays at rest
    ramp_off_a: assert property (@(posedge mclk) disable iff (!nrst) // R9
        !ramp_en |=> !ramp_busy)
        else $error("ramp running while disabled");

endmodule
`default_nettype wire

// ---- verif/test_adar_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_adar_top;
    logic mclk = 0, nrst = 0, wr = 0, ac = 0, inv, busy;
    logic [11:0] a = 0;
    logic [23:0] d = 0, rd;
    logic [7:0] co, fi;
    int fail_count = 0, n_checks = 0, cyc = 0;
    adar_top dut(.mclk, .nrst, .reg_wr(wr), .reg_addr(a), .reg_wdata(d), .reg_rdata(rd),
        .sysref_autocal_enable(ac), .autocal_delay(17'h1A5C3), .sample_clock_invert(inv),
        .coarse_applied(co), .fine_applied(fi), .ramp_busy(busy));
    always #50 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk) if (++cyc > 2000) begin fail_count++; end_of_test; end
    task automatic wreg(logic [11:0] ad, logic [23:0] v);
        @(negedge mclk) {a, d, wr} = {ad, v, 1'b1};
        @(negedge mclk) wr = 0;
    endtask
    task automatic chk(logic [23:0] g, e);
        n_checks++;
        if (g !== e) begin fail_count++; $display("ERROR %0t got %h exp %h", $time, g, e); end
    endtask
    task automatic end_of_test;
        $display("checks %0d fails %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge mclk) nrst = 0;
        nrst = 1; a = 12'h2B5; @(negedge mclk) chk(rd, 24'h0);
        wreg(12'h2B5, 24'h11234); @(negedge mclk) chk({inv, co, fi}, 24'h11234);
        ac = 1; @(negedge mclk) chk({inv, co, fi}, 24'h1A5C3);
        ac = 0; wreg(12'h2B8, 24'h3); wreg(12'h2B5, 24'h01834); repeat (780) @(negedge mclk);
        chk({busy, co}, 24'h18);
        wreg(12'h2B8, 24'h1); wreg(12'h2B5, 24'h01934);
        repeat (10) @(negedge mclk);
        chk({busy, co}, 24'h118);
        wreg(12'h2B5, 24'h01977);
        @(negedge mclk) chk(fi, 24'h77);
        repeat (390) @(negedge mclk);
        chk({busy, co}, 24'h19);
        $display("ramp test done"); end_of_test;
    end
endmodule
`default_nettype wire
